// file: inc/aaf_pkg.sv
// Package: opcodes, state encoding and timing constants of the ALU datapath.
// Assumes the decoder presents one operation per instruction cycle.
package aaf_pkg;
    localparam int unsigned CLK_PERIOD_NS     = 25;
    localparam int unsigned SYS_CLK_PER_INSTR = 4;
    localparam int unsigned EXTRA_PC_LOW_CYCLES = 4;
    localparam int unsigned BCD_LIMIT_DIGIT   = 9;
    localparam logic [3:0]  BCD_LIMIT         = 4'h9;
    localparam logic [7:0]  BCD_LOW_FIX       = 8'h06;
    localparam logic [7:0]  BCD_HIGH_FIX      = 8'h60;
    localparam logic [7:0]  BYTE_ONE          = 8'h01;
    localparam logic [7:0]  BYTE_ZERO         = 8'h00;
    localparam logic [7:0]  WORK_RESET        = 8'h00;

    typedef enum logic [4:0] {
        AAF_NOP       = 5'h00,
        AAF_ADD       = 5'h01,
        AAF_ADC       = 5'h02,
        AAF_SUB       = 5'h03,
        AAF_SUB_BORROW = 5'h04,
        AAF_DECIMAL   = 5'h05,
        AAF_AND       = 5'h06,
        AAF_OR        = 5'h07,
        AAF_XOR       = 5'h08,
        AAF_INVERT    = 5'h09,
        AAF_STEP_UP   = 5'h0a,
        AAF_STEP_DOWN = 5'h0b,
        AAF_ROUND_R   = 5'h0c,
        AAF_ROUND_RC  = 5'h0d,
        AAF_ROUND_L   = 5'h0e,
        AAF_ROUND_LC  = 5'h0f
    } aaf_op_t;

    typedef enum logic [1:0] {
        AAF_ST_IDLE = 2'b00,
        AAF_ST_EXEC = 2'b01,
        AAF_ST_HOLD = 2'b10
    } aaf_state_t;
endpackage : aaf_pkg

// file: inc/aaf_res_if.sv
// Interface: result bundle from the arithmetic core to the sequencer.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface aaf_res_if;
    logic [7:0] result;
    logic       carry;
    logic       half_carry;
    logic       signed_wrap;
    logic       upd_zero;
    logic       upd_carry;
    logic       upd_arith;
    modport core (output result, carry, half_carry, signed_wrap,
                  upd_zero, upd_carry, upd_arith);
    modport seq  (input  result, carry, half_carry, signed_wrap,
                  upd_zero, upd_carry, upd_arith);
endinterface : aaf_res_if

// file: hw/aaf_core.sv
// Combinational arithmetic core: result and flag candidates per opcode.
// Assumes operands are stable for the cycle the sequencer samples them.
`timescale 1ns/1ps
module aaf_core
    import aaf_pkg::*;
(
    input  wire aaf_op_t    op,
    input  wire logic [7:0] work,
    input  wire logic [7:0] operand,
    input  wire logic       carry_in,
    input  wire logic       half_in,
    aaf_res_if.core         res
);
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] b;
    logic       cin;
    logic [7:0] fix;
    logic [8:0] dsum;

    always_comb begin
        b    = operand;
        cin  = 1'b0;
        case (op)
            AAF_ADC: cin = carry_in;
            AAF_SUB: begin
                b   = ~operand;
                cin = 1'b1;
            end
            AAF_SUB_BORROW: begin
                b   = ~operand;
                cin = carry_in;
            end
            default: ;
        endcase
        sum9 = {1'b0, work} + {1'b0, b} + {8'h00, cin};
        sum5 = {1'b0, work[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        fix  = BYTE_ZERO;
        // Half carry covers a low digit that already wrapped past 15
        if (work[3:0] > BCD_LIMIT || half_in)
            fix = fix | BCD_LOW_FIX;
        if (work[7:4] > BCD_LIMIT || carry_in ||
            (work[7:4] == BCD_LIMIT && work[3:0] > BCD_LIMIT))
            fix = fix | BCD_HIGH_FIX;
        dsum = {1'b0, work} + {1'b0, fix};

        res.result      = sum9[7:0];
        res.carry       = sum9[8];
        res.half_carry  = sum5[4];
        res.signed_wrap = (work[7] == b[7]) && (sum9[7] != work[7]);
        res.upd_zero    = 1'b0;
        res.upd_carry   = 1'b0;
        res.upd_arith   = 1'b0;
        case (op)
            AAF_ADD, AAF_ADC, AAF_SUB, AAF_SUB_BORROW: begin
                res.upd_zero  = 1'b1;
                res.upd_carry = 1'b1;
                res.upd_arith = 1'b1;
            end
            AAF_DECIMAL: begin
                res.result    = dsum[7:0];
                res.carry     = dsum[8] | carry_in;
                res.upd_carry = 1'b1;
            end
            AAF_AND: begin
                res.result = work & operand;
                res.upd_zero = 1'b1;
            end
            AAF_OR: begin
                res.result = work | operand;
                res.upd_zero = 1'b1;
            end
            AAF_XOR: begin
                res.result = work ^ operand;
                res.upd_zero = 1'b1;
            end
            AAF_INVERT: begin
                res.result = ~operand;
                res.upd_zero = 1'b1;
            end
            AAF_STEP_UP: begin
                res.result = operand + BYTE_ONE;
                res.upd_zero = 1'b1;
            end
            AAF_STEP_DOWN: begin
                res.result = operand - BYTE_ONE;
                res.upd_zero = 1'b1;
            end
            AAF_ROUND_R:
                res.result = {operand[0], operand[7:1]};
            AAF_ROUND_RC: begin
                res.result = {carry_in, operand[7:1]};
                res.carry  = operand[0];
                res.upd_carry = 1'b1;
            end
            AAF_ROUND_L:
                res.result = {operand[6:0], operand[7]};
            AAF_ROUND_LC: begin
                res.result = {operand[6:0], carry_in};
                res.carry  = operand[7];
                res.upd_carry = 1'b1;
            end
            default: res.result = work;
        endcase
    end
endmodule : aaf_core

// file: hw/aaf_alu.sv
// Accumulator ALU with flag registers and instruction-cycle sequencing.
// Assumes the decoder holds op inputs stable while busy is high.
// Functional notes
// - Add operand to working register, all four flags
// - Add with carry, all four flags
// - Subtract operand from working register, all flags
// - Subtract with borrow via carry, all flags
// - Memory forms write result to memory instead
// - Decimal correct working register into memory, carry
// - AND/OR/XOR to working register, zero only
// - Memory AND/OR/XOR write memory, zero only
// - Invert operand to memory or working, zero
// - Increment operand, zero only, carry kept
// - Decrement operand, zero only, carry kept
// - Rotate right plain, no flags change
// - Rotate right through carry, carry only
// - Rotate left plain, no flags change
// - Rotate left through carry, carry only
// - Low program counter destination adds four clocks
`timescale 1ns/1ps
module aaf_alu
    import aaf_pkg::*;
#(
    parameter int unsigned INSTR_CLKS = SYS_CLK_PER_INSTR,
    parameter int unsigned EXTRA_CLKS = EXTRA_PC_LOW_CYCLES
)
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire aaf_op_t    op,
    input  wire logic       use_immediate,
    input  wire logic       to_memory,
    input  wire logic       to_program_counter_low,
    input  wire logic [7:0] immediate,
    input  wire logic [7:0] mem_rdata,
    output logic            busy,
    output logic            done,
    output logic            mem_we,
    output logic [7:0]      mem_wdata,
    output logic            program_counter_low_we,
    output logic [7:0]      working_register,
    output logic            zero_flag,
    output logic            carry_flag,
    output logic            half_carry_flag,
    output logic            signed_wrap_flag
);
    localparam int CW = 4;
    localparam logic [CW-1:0] LAST_BASE = CW'(INSTR_CLKS - 1);
    localparam logic [CW-1:0] LAST_EXTRA = CW'(EXTRA_CLKS - 1);

    aaf_res_if res ();
    aaf_state_t state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    aaf_op_t    op_q, op_d;
    logic       mem_q, mem_d, pc_low_q, pc_low_d;
    logic [7:0] opnd_q, opnd_d;
    logic [7:0] work_q, work_d, wdata_q, wdata_d;
    logic       z_q, z_d, c_q, c_d, hc_q, hc_d, sw_q, sw_d;
    logic       we_q, we_d, pwe_q, pwe_d, done_q, done_d;

    aaf_core u_core (
        .op       (op_q),
        .work     (work_q),
        .operand  (opnd_q),
        .carry_in (c_q),
        .half_in  (hc_q),
        .res      (res)
    );

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        op_d    = op_q;
        mem_d   = mem_q;
        pc_low_d = pc_low_q;
        opnd_d  = opnd_q;
        work_d  = work_q;
        wdata_d = wdata_q;
        z_d = z_q;
        c_d = c_q;
        hc_d = hc_q;
        sw_d = sw_q;
        we_d = 1'b0;
        pwe_d = 1'b0;
        done_d = 1'b0;
        case (state_q)
            AAF_ST_IDLE: begin
                if (start) begin
                    state_d = AAF_ST_EXEC;
                    cnt_d   = '0;
                    op_d    = op;
                    mem_d   = to_memory || op == AAF_DECIMAL;
                    pc_low_d = to_program_counter_low;
                    opnd_d  = use_immediate ? immediate : mem_rdata;
                end
            end
            AAF_ST_EXEC: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == LAST_BASE) begin
                    cnt_d = '0;
                    if (mem_q) begin
                        wdata_d = res.result;
                        we_d    = 1'b1;
                    end else begin
                        work_d  = res.result;
                    end
                    if (pc_low_q) begin
                        pwe_d   = 1'b1;
                        wdata_d = res.result;
                        state_d = AAF_ST_HOLD;
                    end else begin
                        state_d = AAF_ST_IDLE;
                        done_d  = 1'b1;
                    end
                    if (res.upd_zero)
                        z_d = (res.result == BYTE_ZERO);
                    if (res.upd_carry)
                        c_d = res.carry;
                    if (res.upd_arith) begin
                        hc_d = res.half_carry;
                        sw_d = res.signed_wrap;
                    end
                end
            end
            AAF_ST_HOLD: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == LAST_EXTRA) begin
                    cnt_d   = '0;
                    state_d = AAF_ST_IDLE;
                    done_d  = 1'b1;
                end
            end
            default: state_d = AAF_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= AAF_ST_IDLE;
            cnt_q   <= '0;
            op_q    <= AAF_NOP;
            mem_q   <= 1'b0;
            pc_low_q <= 1'b0;
            opnd_q  <= BYTE_ZERO;
            work_q  <= WORK_RESET;
            wdata_q <= BYTE_ZERO;
            z_q <= 1'b0;
            c_q <= 1'b0;
            hc_q <= 1'b0;
            sw_q <= 1'b0;
            we_q <= 1'b0;
            pwe_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            op_q    <= op_d;
            mem_q   <= mem_d;
            pc_low_q <= pc_low_d;
            opnd_q  <= opnd_d;
            work_q  <= work_d;
            wdata_q <= wdata_d;
            z_q <= z_d;
            c_q <= c_d;
            hc_q <= hc_d;
            sw_q <= sw_d;
            we_q <= we_d;
            pwe_q <= pwe_d;
            done_q <= done_d;
        end
    end

    assign busy             = (state_q != AAF_ST_IDLE);
    assign done             = done_q;
    assign mem_we           = we_q;
    assign mem_wdata        = wdata_q;
    assign program_counter_low_we = pwe_q;
    assign working_register = work_q;
    assign zero_flag        = z_q;
    assign carry_flag       = c_q;
    assign half_carry_flag  = hc_q;
    assign signed_wrap_flag = sw_q;

    property p_zero_upd;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q == AAF_ST_EXEC && cnt_q == LAST_BASE && res.upd_zero)
        |=> (z_q == (($past(res.result)) == BYTE_ZERO));
    endproperty
    a_zero_upd: assert property (p_zero_upd)
        else $error("zero flag does not match result");

    property p_carry_kept;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q == AAF_ST_EXEC && !res.upd_carry) |=> $stable(c_q);
    endproperty
    a_carry_kept: assert property (p_carry_kept)
        else $error("carry changed by non-carry operation");

    property p_arith_kept;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q == AAF_ST_EXEC && !res.upd_arith)
        |=> ($stable(hc_q) && $stable(sw_q));
    endproperty
    a_arith_kept: assert property (p_arith_kept)
        else $error("half carry or wrap changed unexpectedly");

    property p_base_len;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q == AAF_ST_IDLE && start && !to_program_counter_low)
        |-> ##5 done;
    endproperty
    a_base_len: assert property (p_base_len)
        else $error("instruction cycle not four clocks");

    property p_pc_low_len;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q == AAF_ST_IDLE && start && to_program_counter_low)
        |-> ##1 !done [*8] ##1 done;
    endproperty
    a_pc_low_len: assert property (p_pc_low_len)
        else $error("low counter destination not eight clocks");

    property p_mem_dest;
        @(posedge clk_sys) disable iff (!rst_n)
        mem_we |-> $stable(work_q);
    endproperty
    a_mem_dest: assert property (p_mem_dest)
        else $error("memory form changed working register");

    property p_sub_carry;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q == AAF_ST_EXEC && cnt_q == LAST_BASE && op_q == AAF_SUB)
        |=> (c_q == ($past(work_q) >= $past(opnd_q)));
    endproperty
    a_sub_carry: assert property (p_sub_carry)
        else $error("subtract carry is not no-borrow");

    property p_rotr_carry;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q == AAF_ST_EXEC && cnt_q == LAST_BASE
         && op_q == AAF_ROUND_RC)
        |=> (c_q == $past(opnd_q[0]));
    endproperty
    a_rotr_carry: assert property (p_rotr_carry)
        else $error("rotate through carry lost outgoing bit");
endmodule : aaf_alu

// file: sim/aaf_mem_model.sv
// Partner model: byte-wide data memory seen by the ALU datapath.
// Assumes the bench picks the address and preloads operand cells.
`timescale 1ns/1ps
module aaf_mem_model (
    input  wire logic       clk_sys,
    input  wire logic [3:0] addr,
    input  wire logic       mem_we,
    input  wire logic [7:0] mem_wdata,
    output logic      [7:0] mem_rdata
);
    logic [7:0] cells [16];

    // Combinational read keeps the operand settled at the start edge
    assign mem_rdata = cells[addr];

    always @(posedge clk_sys) begin
        if (mem_we) begin
            cells[addr] <= mem_wdata;
        end
    end

    task automatic put(input logic [3:0] a, input logic [7:0] v);
        cells[a] = v;
    endtask : put
endmodule : aaf_mem_model

// file: sim/accumulator_alu_flag_logic_tb.sv
// Testbench: drives the ALU like the decoder, checks results and flags.
// Assumes aaf_pkg, aaf_res_if and the design files are compiled first.
`timescale 1ns/1ps
module accumulator_alu_flag_logic_tb
    import aaf_pkg::*;
;
    logic       clk_sys, rst_n, start, use_immediate, to_memory, to_pc_low;
    aaf_op_t    op;
    logic [7:0] immediate, mem_rdata, mem_wdata, working_register;
    logic       busy, done, mem_we, pc_low_we;
    logic       zero_flag, carry_flag, half_carry_flag, signed_wrap_flag;
    logic [7:0] w_e;
    logic       c_e, z_e, h_e, v_e;
    int         bad_count, checks;

    aaf_alu uut (.clk_sys(clk_sys), .rst_n(rst_n), .start(start),
        .op(op), .use_immediate(use_immediate), .to_memory(to_memory),
        .to_program_counter_low(to_pc_low), .immediate(immediate),
        .mem_rdata(mem_rdata),
        .busy(busy), .done(done), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .program_counter_low_we(pc_low_we),
        .working_register(working_register), .zero_flag(zero_flag),
        .carry_flag(carry_flag), .half_carry_flag(half_carry_flag),
        .signed_wrap_flag(signed_wrap_flag));

    aaf_mem_model mem (.clk_sys(clk_sys), .addr(4'h3), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    task automatic chk(input string nm, input logic [7:0] s, e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic finish_test;
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    // One instruction: predict, issue, wait for done, compare
    task automatic run(input aaf_op_t o, input logic im, tm,
                       input logic [7:0] v, input logic rf = 1'b0,
                       input logic pc = 1'b0);
        logic [7:0] b, r, pd;
        logic [8:0] s, t;
        logic       ci, hc, hi;
        int         n, pn;
        b  = (o == AAF_SUB || o == AAF_SUB_BORROW) ? ~v : v;
        ci = (o == AAF_ADD) ? 1'b0 : (o == AAF_SUB) ? 1'b1 : c_e;
        s  = w_e + b + ci;
        hc = ({1'b0, w_e[3:0]} + b[3:0] + ci) > 5'h0f;
        hi = w_e[7:4] > 4'h9 || c_e || (w_e[7:4] == 4'h9 && w_e[3:0] > 4'h9);
        t  = {1'b0, w_e} + ((w_e[3:0] > 4'h9 || h_e) ? 9'h006 : 9'h000)
             + (hi ? 9'h060 : 9'h000);
        case (o)
            AAF_ADD, AAF_ADC, AAF_SUB, AAF_SUB_BORROW: begin
                r   = s[7:0];
                c_e = s[8];
                h_e = hc;
                v_e = (w_e[7] == b[7]) && (r[7] != w_e[7]);
            end
            AAF_DECIMAL: begin
                r   = t[7:0];
                c_e = t[8] | c_e;
            end
            AAF_AND:       r = w_e & v;
            AAF_OR:        r = w_e | v;
            AAF_XOR:       r = w_e ^ v;
            AAF_INVERT:    r = ~v;
            AAF_STEP_UP:   r = v + 8'h01;
            AAF_STEP_DOWN: r = v - 8'h01;
            AAF_ROUND_R:   r = {v[0], v[7:1]};
            AAF_ROUND_L:   r = {v[6:0], v[7]};
            AAF_ROUND_RC: begin
                r   = {c_e, v[7:1]};
                c_e = v[0];
            end
            AAF_ROUND_LC: begin
                r   = {v[6:0], c_e};
                c_e = v[7];
            end
            default:       r = w_e;
        endcase
        if (o inside {[AAF_ADD:AAF_STEP_DOWN]} && o != AAF_DECIMAL) begin
            z_e = (r == 8'h00);
        end
        if (!tm && o != AAF_DECIMAL) begin
            w_e = r;
        end
        mem.put(4'h3, im ? ~v : v);
        op = o;
        use_immediate = im;
        to_memory = tm;
        to_pc_low = pc;
        immediate = v;
        start = 1'b1;
        @(posedge clk_sys);
        #1;
        start = 1'b0;
        n = 0;
        pn = 0;
        pd = 8'h00;
        while (done !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
            start = rf && n == 2;
            if (pc_low_we === 1'b1) begin
                pn = n;
                pd = mem_wdata;
            end
        end
        chk("cycles", 8'(n), pc ? 8'h08 : 8'h04);
        chk("pc_low_cycle", 8'(pn), pc ? 8'h04 : 8'h00);
        if (pc) begin
            chk("pc_low_data", pd, r);
        end else begin
            chk("work", working_register, w_e);
            chk("zero", zero_flag, z_e);
            chk("carry", carry_flag, c_e);
            chk("half", half_carry_flag, h_e);
            chk("wrap", signed_wrap_flag, v_e);
            chk("mem_we", mem_we, tm || o == AAF_DECIMAL);
            if (mem_we === 1'b1) begin
                chk("mem_data", mem_wdata, r);
            end
        end
    endtask : run

    task automatic t_reset;
        chk("rst_work", working_register, 8'h00);
        chk("rst_ctl", {busy, done, mem_we, pc_low_we, zero_flag, carry_flag,
            half_carry_flag, signed_wrap_flag}, 8'h00);
    endtask : t_reset

    task automatic t_arith;
        aaf_op_t    ops [8];
        logic [7:0] vs  [8];
        ops = '{AAF_ADD, AAF_ADD, AAF_ADC, AAF_ADC,
                AAF_SUB, AAF_SUB_BORROW, AAF_SUB, AAF_SUB_BORROW};
        vs  = '{8'h7f, 8'h81, 8'hff, 8'h0f, 8'h81, 8'h7d, 8'h00, 8'h01};
        for (int i = 0; i < 8; i++) begin
            run(ops[i], i == 0 || i == 4, i[0], vs[i]);
        end
    endtask : t_arith

    task automatic t_logic;
        run(AAF_AND, 1'b1, 1'b0, 8'h3c);
        run(AAF_OR, 1'b0, 1'b1, 8'hc3);
        run(AAF_XOR, 1'b0, 1'b0, w_e);
        run(AAF_OR, 1'b1, 1'b0, 8'h5a);
        run(AAF_AND, 1'b0, 1'b1, 8'h00);
        run(AAF_XOR, 1'b0, 1'b1, 8'h11);
    endtask : t_logic

    task automatic t_unary;
        run(AAF_SUB, 1'b1, 1'b0, 8'h00);
        run(AAF_INVERT, 1'b0, 1'b0, 8'hff);
        run(AAF_INVERT, 1'b0, 1'b1, 8'h0f);
        run(AAF_STEP_UP, 1'b0, 1'b0, 8'hff);
        run(AAF_STEP_UP, 1'b0, 1'b1, 8'h7f);
        run(AAF_STEP_DOWN, 1'b0, 1'b0, 8'h01);
        run(AAF_STEP_DOWN, 1'b0, 1'b1, 8'h00);
    endtask : t_unary

    task automatic t_rotate;
        for (int i = 0; i < 16; i++) begin
            run(aaf_op_t'(AAF_ROUND_R + i[3:2]), 1'b0, i[1],
                i[0] ? 8'h81 : 8'h02);
        end
    endtask : t_rotate

    task automatic t_decimal;
        logic [7:0] a [4];
        a = '{8'h45, 8'h50, 8'h4d, 8'h99};
        for (int i = 0; i < 4; i++) begin
            run(AAF_AND, 1'b1, 1'b0, 8'h00);
            run(AAF_ADD, 1'b1, 1'b0, a[i]);
            run(AAF_ADD, 1'b1, 1'b0, a[i]);
            run(AAF_DECIMAL, 1'b0, 1'b1, 8'h00);
        end
    endtask : t_decimal

    task automatic t_refuse;
        run(AAF_ADD, 1'b1, 1'b0, 8'h21, 1'b1);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("busy_idle", busy, 1'b0);
        chk("work_kept", working_register, w_e);
    endtask : t_refuse

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial begin
        #100_000;
        bad_count++;
        finish_test;
    end

    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        op = AAF_NOP;
        use_immediate = 1'b0;
        to_memory = 1'b0;
        to_pc_low = 1'b0;
        immediate = 8'h00;
        {w_e, c_e, z_e, h_e, v_e} = 12'h000;
        bad_count = 0;
        checks = 0;
        repeat (6) @(posedge clk_sys);
        #1;
        t_reset;
        rst_n = 1'b1;
        t_arith;
        t_logic;
        t_unary;
        t_rotate;
        t_decimal;
        t_refuse;
        run(AAF_ADD, 1'b1, 1'b0, 8'h10, 1'b0, 1'b1);
        finish_test;
    end
endmodule : accumulator_alu_flag_logic_tb
